// ---- spimi_master.sv ----
// Serial peripheral master with FIFOs, five interrupt sources and mask logic.
// How it works
// - Receive threshold irq while fill above threshold.
// - Sticky receive overflow, cleared by clear read.
// - Sticky receive underflow on empty data read.
// - Sticky transmit overflow on full data write.
// - Transmit threshold irq while fill below threshold.
// - Raw status shows all five sources unmasked.
// - Per-source mask bit, all enabled after reset.
// - Masked status is raw and mask combined.
// - Interrupt out needs enabled source and controller.
// - Config 0x10F means 16-bit transmit only.
// - Slave-select bit n drives chip select n.
// - Queued frames go back to back, one select.
// - Select held all transfer, ends when empty.
// - Busy lags writes; check empty and busy.
// - Transmit-only drops receive data, runs while queued.
`timescale 1ns/1ps
module spimi_master (
	input  wire logic                              i_mclk,
	input  wire logic                              i_sys_rst,
	input  wire logic                              i_ena,
	input  wire logic [1:0]                        i_owner_sel,
	input  wire logic                              i_controller_enable,
	input  wire logic [spimi_pkg::BAUD_W-1:0]      i_baud_divisor,
	input  wire logic [spimi_pkg::CFG_W-1:0]       i_transaction_config,
	input  wire logic [spimi_pkg::NCS-1:0]         i_slave_select_mask,
	input  wire logic [spimi_pkg::LVL_W-1:0]       i_tx_threshold_level,
	input  wire logic [spimi_pkg::LVL_W-1:0]       i_rx_threshold_level,
	input  wire logic                              i_irq_mask_wr,
	input  wire logic [spimi_pkg::NIRQ-1:0]        i_irq_mask_data,
	input  wire logic                              i_fifo_data_port_wr,
	input  wire logic [spimi_pkg::DATA_W-1:0]      i_fifo_data_port_wdata,
	input  wire logic                              i_fifo_data_port_rd,
	input  wire logic                              i_rx_overflow_clear,
	input  wire logic                              i_rx_underflow_clear,
	input  wire logic                              i_tx_overflow_clear,
	input  wire logic                              i_miso,
	output logic                                   o_sclk,
	output logic                                   o_mosi,
	output logic [spimi_pkg::NCS-1:0]              o_chip_select_n,
	output logic [spimi_pkg::DATA_W-1:0]           o_fifo_data_port_rdata,
	output logic                                   o_fifo_data_port_rvalid,
	output logic                                   o_tx_full,
	output logic                                   o_tx_fifo_empty,
	output logic                                   o_busy,
	output logic [spimi_pkg::LVL_W-1:0]            o_tx_fill_level,
	output logic [spimi_pkg::LVL_W-1:0]            o_rx_fill_level,
	output logic [spimi_pkg::NIRQ-1:0]             o_irq_mask,
	output logic [spimi_pkg::NIRQ-1:0]             o_raw_irq_status,
	output logic [spimi_pkg::NIRQ-1:0]             o_masked_irq_status,
	output logic                                   o_irq
);
	import spimi_pkg::*;

	spimi_state_t        state_ff, nxt_state;
	logic [BAUD_W-1:0]   baud_cnt_ff, nxt_baud_cnt;
	logic                sclk_ff, nxt_sclk;
	logic                mosi_ff, nxt_mosi;
	logic [NCS-1:0]      cs_n_ff, nxt_cs_n;
	logic [3:0]          bit_cnt_ff, nxt_bit_cnt;
	logic [DATA_W-1:0]   tx_word_ff, nxt_tx_word;
	logic [DATA_W-1:0]   rx_sh_ff, nxt_rx_sh;
	logic                busy_ff, nxt_busy;
	logic [DATA_W-1:0]   rdata_ff, nxt_rdata;
	logic                rvalid_ff, nxt_rvalid;
	logic                tx_empty_ff, nxt_tx_empty;
	logic [NIRQ-1:0]     mask_ff, nxt_mask;
	logic [NIRQ-1:0]     raw_ff, nxt_raw;
	logic [NIRQ-1:0]     masked_ff, nxt_masked;
	logic                irq_ff, nxt_irq;
	logic                tx_full_ff, nxt_tx_full;

	logic                tx_wr_ready;
	logic                tx_rd_valid;
	logic [DATA_W-1:0]   tx_head;
	logic                tx_pop;
	logic [LVL_W-1:0]    tx_count;
	logic                stg_wr_ready;
	logic                stg_rd_valid;
	logic [DATA_W-1:0]   stg_rd_data;
	logic                rx_wr_ready;
	logic                rx_rd_valid;
	logic [DATA_W-1:0]   rx_head;
	logic                rx_pop;
	logic [LVL_W-1:0]    rx_count;
	logic                rx_push;
	logic [DATA_W-1:0]   frame_mask;
	logic [DATA_W-1:0]   rx_frame;
	logic [3:0]          dfs_raw;
	logic [3:0]          dfs_eff;
	logic [1:0]          transfer_mode;
	logic [BAUD_W-1:0]   half_period;
	logic [BAUD_W-1:0]   half_m1;
	logic                run_ok;
	logic                ev_tx_ovf;
	logic                ev_rx_ovf;
	logic                ev_rx_unf;

	assign dfs_raw     = i_transaction_config[CFG_DFS_LSB +: 4];
	assign dfs_eff     = (dfs_raw < DFS_MIN) ? DFS_MIN : dfs_raw;
	assign transfer_mode        = i_transaction_config[CFG_TRANSFER_MODE_LSB +: 2];
	assign half_period = (i_baud_divisor[BAUD_W-1:1] == '0) ? HALF_MIN : {1'b0, i_baud_divisor[BAUD_W-1:1]};
	assign half_m1     = half_period - HALF_MIN;
	assign run_ok      = i_controller_enable && (i_owner_sel == OWNER_MASTER);

	// Only the bits of the programmed frame size are kept from the shifter.
	for (genvar b = 0; b < DATA_W; b++)
	begin : g_mask
		assign frame_mask[b] = (4'(b) <= dfs_eff);
	end
	assign rx_frame = rx_sh_ff & frame_mask;

	spimi_fifo #(
		.W     (DATA_W),
		.DEPTH (TX_DEPTH)
	) u_tx_fifo (
		.i_mclk     (i_mclk),
		.i_sys_rst  (i_sys_rst),
		.i_ena      (i_ena),
		.i_wr_valid (i_fifo_data_port_wr),
		.i_wr_data  (i_fifo_data_port_wdata),
		.o_wr_ready (tx_wr_ready),
		.o_rd_valid (tx_rd_valid),
		.o_rd_data  (tx_head),
		.i_rd_ready (tx_pop),
		.o_count    (tx_count)
	);

	// Two-entry stage between the shifter and the receive FIFO, so a full FIFO backs up before a word is lost.
	spimi_fifo #(
		.W     (DATA_W),
		.DEPTH (STAGE_DEPTH)
	) u_rx_stage (
		.i_mclk     (i_mclk),
		.i_sys_rst  (i_sys_rst),
		.i_ena      (i_ena),
		.i_wr_valid (rx_push),
		.i_wr_data  (rx_frame),
		.o_wr_ready (stg_wr_ready),
		.o_rd_valid (stg_rd_valid),
		.o_rd_data  (stg_rd_data),
		.i_rd_ready (rx_wr_ready),
		.o_count    ()
	);

	spimi_fifo #(
		.W     (DATA_W),
		.DEPTH (RX_DEPTH)
	) u_rx_fifo (
		.i_mclk     (i_mclk),
		.i_sys_rst  (i_sys_rst),
		.i_ena      (i_ena),
		.i_wr_valid (stg_rd_valid),
		.i_wr_data  (stg_rd_data),
		.o_wr_ready (rx_wr_ready),
		.o_rd_valid (rx_rd_valid),
		.o_rd_data  (rx_head),
		.i_rd_ready (rx_pop),
		.o_count    (rx_count)
	);

	// Serial engine; mode 0 clocking, data sampled on the rising edge and changed on the falling edge.
	always_comb
	begin
		nxt_state    = state_ff;
		nxt_baud_cnt = baud_cnt_ff;
		nxt_sclk     = sclk_ff;
		nxt_mosi     = mosi_ff;
		nxt_cs_n     = cs_n_ff;
		nxt_bit_cnt  = bit_cnt_ff;
		nxt_tx_word  = tx_word_ff;
		nxt_rx_sh    = rx_sh_ff;
		tx_pop       = 1'b0;
		rx_push      = 1'b0;
		unique case (state_ff)
			spimi_idle:
			begin
				nxt_cs_n = CS_IDLE;
				nxt_sclk = 1'b0;
				if (run_ok && tx_rd_valid)
				begin
					tx_pop       = 1'b1;
					nxt_tx_word  = tx_head;
					nxt_bit_cnt  = dfs_eff;
					nxt_mosi     = tx_head[dfs_eff];
					nxt_cs_n     = ~i_slave_select_mask;
					nxt_baud_cnt = '0;
					nxt_state    = spimi_shift;
				end
			end
			spimi_shift:
			begin
				if (!run_ok)
					nxt_state = spimi_end;
				else if (baud_cnt_ff != half_m1)
					nxt_baud_cnt = baud_cnt_ff + HALF_MIN;
				else
				begin
					nxt_baud_cnt = '0;
					nxt_sclk     = ~sclk_ff;
					if (!sclk_ff)
						nxt_rx_sh = {rx_sh_ff[DATA_W-2:0], i_miso};
					else if (bit_cnt_ff != 4'h0)
					begin
						nxt_bit_cnt = bit_cnt_ff - 4'h1;
						nxt_mosi    = tx_word_ff[bit_cnt_ff - 4'h1];
					end
					else
					begin
						rx_push = (transfer_mode != TRANSFER_MODE_TX_ONLY);
						if (tx_rd_valid)
						begin
							tx_pop      = 1'b1;
							nxt_tx_word = tx_head;
							nxt_bit_cnt = dfs_eff;
							nxt_mosi    = tx_head[dfs_eff];
						end
						else
							nxt_state = spimi_end;
					end
				end
			end
			spimi_end:
			begin
				nxt_cs_n  = CS_IDLE;
				nxt_sclk  = 1'b0;
				nxt_state = spimi_idle;
			end
			default:
				nxt_state = spimi_idle;
		endcase
		nxt_busy = (nxt_state != spimi_idle);
	end

	always_ff @(posedge i_mclk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			state_ff    <= spimi_idle;
			baud_cnt_ff <= '0;
			sclk_ff     <= 1'b0;
			mosi_ff     <= 1'b0;
			cs_n_ff     <= CS_IDLE;
			bit_cnt_ff  <= 4'h0;
			tx_word_ff  <= WORD_RST;
			rx_sh_ff    <= WORD_RST;
			busy_ff     <= 1'b0;
		end
		else if (i_ena)
		begin
			state_ff    <= nxt_state;
			baud_cnt_ff <= nxt_baud_cnt;
			sclk_ff     <= nxt_sclk;
			mosi_ff     <= nxt_mosi;
			cs_n_ff     <= nxt_cs_n;
			bit_cnt_ff  <= nxt_bit_cnt;
			tx_word_ff  <= nxt_tx_word;
			rx_sh_ff    <= nxt_rx_sh;
			busy_ff     <= nxt_busy;
		end
	end

	// Software side of the data port and the interrupt sources.
	always_comb
	begin
		ev_tx_ovf    = i_fifo_data_port_wr && !tx_wr_ready;
		ev_rx_ovf    = rx_push && !stg_wr_ready;
		ev_rx_unf    = i_fifo_data_port_rd && !rx_rd_valid;
		rx_pop       = i_fifo_data_port_rd && rx_rd_valid;
		nxt_rdata    = rx_pop ? rx_head : rdata_ff;
		nxt_rvalid   = rx_pop;
		nxt_tx_empty = !tx_rd_valid;
		// Full is rebuilt from the count so the pin comes straight from a flop and never lags the FIFO.
		nxt_tx_full  = (tx_count + LVL_W'(i_fifo_data_port_wr && tx_wr_ready) - LVL_W'(tx_pop)) == LVL_W'(TX_DEPTH);
		nxt_mask     = i_irq_mask_wr ? i_irq_mask_data : mask_ff;
		nxt_raw      = raw_ff;
		nxt_raw[IRQ_RX_THR] = ({1'b0, rx_count} > {1'b0, i_rx_threshold_level});
		nxt_raw[IRQ_TX_THR] = ({1'b0, tx_count} < {1'b0, i_tx_threshold_level});
		// A new event in the cycle of a clear read keeps the flag set.
		nxt_raw[IRQ_RX_OVF] = ev_rx_ovf || (raw_ff[IRQ_RX_OVF] && !i_rx_overflow_clear);
		nxt_raw[IRQ_RX_UNF] = ev_rx_unf || (raw_ff[IRQ_RX_UNF] && !i_rx_underflow_clear);
		nxt_raw[IRQ_TX_OVF] = ev_tx_ovf || (raw_ff[IRQ_TX_OVF] && !i_tx_overflow_clear);
		nxt_masked = raw_ff & mask_ff;
		nxt_irq    = (|masked_ff) && i_controller_enable;
	end

	always_ff @(posedge i_mclk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			rdata_ff    <= WORD_RST;
			rvalid_ff   <= 1'b0;
			tx_empty_ff <= 1'b1;
			tx_full_ff  <= 1'b0;
			mask_ff     <= IRQ_MASK_RST;
			raw_ff      <= IRQ_RST;
			masked_ff   <= IRQ_RST;
			irq_ff      <= 1'b0;
		end
		else if (i_ena)
		begin
			rdata_ff    <= nxt_rdata;
			rvalid_ff   <= nxt_rvalid;
			tx_empty_ff <= nxt_tx_empty;
			tx_full_ff  <= nxt_tx_full;
			mask_ff     <= nxt_mask;
			raw_ff      <= nxt_raw;
			masked_ff   <= nxt_masked;
			irq_ff      <= nxt_irq;
		end
	end

	assign o_sclk                  = sclk_ff;
	assign o_mosi                  = mosi_ff;
	assign o_chip_select_n         = cs_n_ff;
	assign o_fifo_data_port_rdata  = rdata_ff;
	assign o_fifo_data_port_rvalid = rvalid_ff;
	assign o_tx_full               = tx_full_ff;
	assign o_tx_fifo_empty         = tx_empty_ff;
	assign o_busy                  = busy_ff;
	assign o_tx_fill_level         = tx_count;
	assign o_rx_fill_level         = rx_count;
	assign o_irq_mask              = mask_ff;
	assign o_raw_irq_status        = raw_ff;
	assign o_masked_irq_status     = masked_ff;
	assign o_irq                   = irq_ff;
endmodule : spimi_master

// ---- spimi_pkg.sv ----
// Constants, field layouts and types shared by the serial master with interrupts.
package spimi_pkg;
	localparam int         DATA_W       = 16;
	localparam int         TX_DEPTH     = 8;
	localparam int         RX_DEPTH     = 8;
	localparam int         STAGE_DEPTH  = 2;
	localparam int         LVL_W        = 4;
	localparam int         NCS          = 5;
	localparam int         NIRQ         = 5;
	localparam int         BAUD_W       = 16;
	localparam int         CFG_W        = 16;
	localparam int         CFG_DFS_LSB  = 0;
	localparam int         CFG_TRANSFER_MODE_LSB = 8;
	localparam logic [1:0] OWNER_MASTER = 2'h2;
	localparam logic [1:0] TRANSFER_MODE_TX_RX   = 2'h0;
	localparam logic [1:0] TRANSFER_MODE_TX_ONLY = 2'h1;
	localparam logic [3:0] DFS_MIN      = 4'h3;
	localparam int         IRQ_TX_THR   = 0;
	localparam int         IRQ_TX_OVF   = 1;
	localparam int         IRQ_RX_UNF   = 2;
	localparam int         IRQ_RX_OVF   = 3;
	localparam int         IRQ_RX_THR   = 4;
	localparam logic [NIRQ-1:0]   IRQ_MASK_RST = 5'h1f;
	localparam logic [NIRQ-1:0]   IRQ_RST      = 5'h00;
	localparam logic [NCS-1:0]    CS_IDLE      = 5'h1f;
	localparam logic [BAUD_W-1:0] HALF_MIN     = 16'h0001;
	localparam logic [DATA_W-1:0] WORD_RST     = 16'h0000;

	typedef enum logic [1:0]
	{
		spimi_idle  = 2'b00,
		spimi_shift = 2'b01,
		spimi_end   = 2'b11
	} spimi_state_t;
endpackage : spimi_pkg

// ---- spimi_fifo.sv ----
// Flip-flop FIFO with valid and ready on both sides and registered flags.
`timescale 1ns/1ps
module spimi_fifo #(
	parameter int W     = 16,
	parameter int DEPTH = 8
) (
	input  wire logic                       i_mclk,
	input  wire logic                       i_sys_rst,
	input  wire logic                       i_ena,
	input  wire logic                       i_wr_valid,
	input  wire logic [W-1:0]               i_wr_data,
	output logic                            o_wr_ready,
	output logic                            o_rd_valid,
	output logic [W-1:0]                    o_rd_data,
	input  wire logic                       i_rd_ready,
	output logic [$clog2(DEPTH+1)-1:0]      o_count
);
	localparam int IW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [IW-1:0] LAST = IW'(DEPTH - 1);
	localparam logic [CW-1:0] FULL = CW'(DEPTH);

	logic [W-1:0]  mem_ff [DEPTH];
	logic [IW-1:0] wr_idx_ff, nxt_wr_idx;
	logic [IW-1:0] rd_idx_ff, nxt_rd_idx;
	logic [CW-1:0] count_ff, nxt_count;
	logic          ready_ff, nxt_ready;
	logic          valid_ff, nxt_valid;
	logic          do_wr;
	logic          do_rd;

	always_comb
	begin
		do_wr      = i_wr_valid & ready_ff;
		do_rd      = i_rd_ready & valid_ff;
		nxt_wr_idx = wr_idx_ff;
		nxt_rd_idx = rd_idx_ff;
		nxt_count  = count_ff;
		if (do_wr)
			nxt_wr_idx = (wr_idx_ff == LAST) ? '0 : wr_idx_ff + IW'(1);
		if (do_rd)
			nxt_rd_idx = (rd_idx_ff == LAST) ? '0 : rd_idx_ff + IW'(1);
		if (do_wr && !do_rd)
			nxt_count = count_ff + CW'(1);
		else if (do_rd && !do_wr)
			nxt_count = count_ff - CW'(1);
		nxt_ready = (nxt_count != FULL);
		nxt_valid = (nxt_count != '0);
	end

	always_ff @(posedge i_mclk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			wr_idx_ff <= '0;
			rd_idx_ff <= '0;
			count_ff  <= '0;
			ready_ff  <= 1'b1;
			valid_ff  <= 1'b0;
		end
		else if (i_ena)
		begin
			wr_idx_ff <= nxt_wr_idx;
			rd_idx_ff <= nxt_rd_idx;
			count_ff  <= nxt_count;
			ready_ff  <= nxt_ready;
			valid_ff  <= nxt_valid;
		end
	end

	for (genvar e = 0; e < DEPTH; e++)
	begin : g_entry
		logic [W-1:0] nxt_mem;
		always_comb
		begin
			nxt_mem = mem_ff[e];
			if (do_wr && wr_idx_ff == IW'(e))
				nxt_mem = i_wr_data;
		end
		always_ff @(posedge i_mclk or posedge i_sys_rst)
		begin
			if (i_sys_rst)
				mem_ff[e] <= '0;
			else if (i_ena)
				mem_ff[e] <= nxt_mem;
		end
	end

	assign o_wr_ready = ready_ff;
	assign o_rd_valid = valid_ff;
	assign o_rd_data  = mem_ff[rd_idx_ff];
	assign o_count    = count_ff;
endmodule : spimi_fifo

// ---- spimi_master_sva.sv ----
// Port-level assertions for the serial master, with their bind.
`timescale 1ns/1ps
module spimi_master_sva (
	input wire logic       i_mclk,
	input wire logic       i_sys_rst,
	input wire logic       i_ena,
	input wire logic       i_controller_enable,
	input wire logic [3:0] i_tx_threshold_level,
	input wire logic [3:0] i_rx_threshold_level,
	input wire logic       i_irq_mask_wr,
	input wire logic [4:0] i_irq_mask_data,
	input wire logic       i_fifo_data_port_wr,
	input wire logic       i_fifo_data_port_rd,
	input wire logic       i_rx_overflow_clear,
	input wire logic       i_tx_overflow_clear,
	input wire logic [4:0] o_chip_select_n,
	input wire logic       o_tx_full,
	input wire logic       o_busy,
	input wire logic [3:0] o_tx_fill_level,
	input wire logic [3:0] o_rx_fill_level,
	input wire logic [4:0] o_irq_mask,
	input wire logic [4:0] o_raw_irq_status,
	input wire logic [4:0] o_masked_irq_status,
	input wire logic       o_irq
);
	import spimi_pkg::*;
	logic run_ff;
	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (i_sys_rst);
	// The first edge after reset is skipped, since the status pipeline is still filling then.
	always_ff @(posedge i_mclk or posedge i_sys_rst)
		if (i_sys_rst)
			run_ff <= 1'b0;
		else
			run_ff <= i_ena;
	mask_load_a: assert property (i_ena && i_irq_mask_wr |=> o_irq_mask == $past(i_irq_mask_data))
		else $error("mask write not taken");
	masked_view_a: assert property (run_ff |-> o_masked_irq_status == $past(o_raw_irq_status & o_irq_mask))
		else $error("masked status wrong");
	irq_gate_a: assert property (run_ff |-> o_irq == $past(|o_masked_irq_status && i_controller_enable))
		else $error("irq output wrong");
	tx_level_a: assert property (run_ff
		|-> o_raw_irq_status[IRQ_TX_THR] == $past(o_tx_fill_level < i_tx_threshold_level))
		else $error("tx threshold irq wrong");
	rx_level_a: assert property (run_ff
		|-> o_raw_irq_status[IRQ_RX_THR] == $past(o_rx_fill_level > i_rx_threshold_level))
		else $error("rx threshold irq wrong");
	tx_ovf_set_a: assert property (i_ena && i_fifo_data_port_wr && o_tx_full |=> o_raw_irq_status[IRQ_TX_OVF])
		else $error("tx overflow not flagged");
	tx_ovf_clr_a: assert property (i_ena && i_tx_overflow_clear && !(i_fifo_data_port_wr && o_tx_full)
		|=> !o_raw_irq_status[IRQ_TX_OVF])
		else $error("tx overflow not cleared");
	rx_unf_set_a: assert property (i_ena && i_fifo_data_port_rd && o_rx_fill_level == 4'h0
		|=> o_raw_irq_status[IRQ_RX_UNF])
		else $error("rx underflow not flagged");
	rx_ovf_hold_a: assert property (i_ena && o_raw_irq_status[IRQ_RX_OVF] && !i_rx_overflow_clear
		|=> o_raw_irq_status[IRQ_RX_OVF])
		else $error("rx overflow not sticky");
	cs_idle_a: assert property (!o_busy |-> o_chip_select_n == CS_IDLE)
		else $error("select low while idle");
endmodule : spimi_master_sva
bind spimi_master spimi_master_sva u_sva (
	.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_ena(i_ena), .i_controller_enable(i_controller_enable),
	.i_tx_threshold_level(i_tx_threshold_level), .i_rx_threshold_level(i_rx_threshold_level),
	.i_irq_mask_wr(i_irq_mask_wr), .i_irq_mask_data(i_irq_mask_data),
	.i_fifo_data_port_wr(i_fifo_data_port_wr), .i_fifo_data_port_rd(i_fifo_data_port_rd),
	.i_rx_overflow_clear(i_rx_overflow_clear), .i_tx_overflow_clear(i_tx_overflow_clear),
	.o_chip_select_n(o_chip_select_n), .o_tx_full(o_tx_full), .o_busy(o_busy),
	.o_tx_fill_level(o_tx_fill_level), .o_rx_fill_level(o_rx_fill_level), .o_irq_mask(o_irq_mask),
	.o_raw_irq_status(o_raw_irq_status), .o_masked_irq_status(o_masked_irq_status), .o_irq(o_irq)
);

// ---- spimi_slave_model.sv ----
// Behavioural serial slave that records what it hears and answers a fixed word.
`timescale 1ns/1ps
module spimi_slave_model #(
	parameter logic [15:0] REPLY = 16'ha5c3
) (
	input  wire logic        i_sclk,
	input  wire logic        i_cs_n,
	input  wire logic        i_mosi,
	output logic             o_miso,
	output logic [63:0]      o_heard,
	output int               o_bits,
	output int               o_selects
);
	logic [15:0] sh;
	initial
	begin
		o_miso = 1'b1;
		o_heard = '0;
		o_bits = 0;
		o_selects = 0;
		sh = REPLY;
	end
	always @(negedge i_cs_n)
	begin
		o_selects = o_selects + 1;
		sh = REPLY;
		o_miso = sh[15];
	end
	// A released line shows the inverse, so a stale bit can never pass for data.
	always @(posedge i_cs_n)
		o_miso = ~o_miso;
	always @(posedge i_sclk)
		if (!i_cs_n)
		begin
			o_heard = {o_heard[62:0], i_mosi};
			o_bits = o_bits + 1;
		end
	always @(negedge i_sclk)
		if (!i_cs_n)
		begin
			sh = (o_bits % 16 == 0) ? REPLY : sh << 1;
			o_miso = sh[15];
		end
endmodule : spimi_slave_model

// ---- spimi_master_tb.sv ----
// Self-checking bench for the serial master: bring-up, transfers and interrupts.
`timescale 1ns/1ps
module spimi_master_tb;
	import spimi_pkg::*;
	logic        clk = 1'b0, rst = 1'b1, en = 1'b0, wr = 1'b0, rd = 1'b0, mwr = 1'b0;
	logic        rxoc = 1'b0, rxuc = 1'b0, txoc = 1'b0, miso, sclk, mosi, rvalid, full, tx_fifo_empty, busy, irq;
	logic        cs_other = 1'b0, ena = 1'b1;
	logic [1:0]  own = 2'h0;
	logic [15:0] baud = 16'h00fa, cfg = 16'h010f, wd = 16'h0000, rdata;
	logic [4:0]  ssm = 5'h02, mdat = 5'h1f, csn, mask, raw, mskd;
	logic [3:0]  txt = 4'h0, rxt = 4'h0, txl, rxl;
	logic [63:0] heard;
	int          bits, sels, n_fail = 0, checks_done = 0;
	always #2.5 clk = ~clk;
	spimi_master DUT (
		.i_mclk(clk), .i_sys_rst(rst), .i_ena(ena), .i_owner_sel(own), .i_controller_enable(en),
		.i_baud_divisor(baud), .i_transaction_config(cfg), .i_slave_select_mask(ssm),
		.i_tx_threshold_level(txt), .i_rx_threshold_level(rxt), .i_irq_mask_wr(mwr), .i_irq_mask_data(mdat),
		.i_fifo_data_port_wr(wr), .i_fifo_data_port_wdata(wd), .i_fifo_data_port_rd(rd),
		.i_rx_overflow_clear(rxoc), .i_rx_underflow_clear(rxuc), .i_tx_overflow_clear(txoc), .i_miso(miso),
		.o_sclk(sclk), .o_mosi(mosi), .o_chip_select_n(csn), .o_fifo_data_port_rdata(rdata),
		.o_fifo_data_port_rvalid(rvalid), .o_tx_full(full), .o_tx_fifo_empty(tx_fifo_empty), .o_busy(busy),
		.o_tx_fill_level(txl), .o_rx_fill_level(rxl), .o_irq_mask(mask), .o_raw_irq_status(raw),
		.o_masked_irq_status(mskd), .o_irq(irq)
	);
	spimi_slave_model u_slave (
		.i_sclk(sclk), .i_cs_n(csn[1]), .i_mosi(mosi), .o_miso(miso),
		.o_heard(heard), .o_bits(bits), .o_selects(sels)
	);
	always @(posedge clk)
		if (!rst && (csn[0] !== 1'b1 || csn[4:2] !== 3'h7))
			cs_other <= 1'b1;
	task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
		checks_done++;
		if (got !== exp)
		begin
			n_fail++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick
	task automatic put(input logic [15:0] d);
		@(posedge clk);
		wr <= 1'b1;
		wd <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask : put
	task automatic pulse(input int which);
		@(posedge clk);
		rd <= (which == 0);
		rxoc <= (which == 1);
		rxuc <= (which == 2);
		txoc <= (which == 3);
		mwr <= (which == 4);
		@(posedge clk);
		{rd, rxoc, rxuc, txoc, mwr} <= 5'h00;
	endtask : pulse
	// Busy lags the writes, so both flags are watched and a few cycles pass first.
	task automatic wait_idle();
		int k;
		k = 0;
		tick(4);
		while (!(tx_fifo_empty === 1'b1 && busy === 1'b0) && k < 40000)
		begin
			tick(1);
			k++;
		end
		chk("idle", 1, k < 40000);
	endtask : wait_idle
	task automatic close_out();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : close_out
	initial
	begin
		#300000;
		n_fail++;
		close_out();
	end
	initial
	begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		tick(3);
		chk("mask", 5'h1f, mask);
		chk("raw", 5'h00, raw);
		chk("select", 5'h1f, csn);
		@(posedge clk);
		en <= 1'b1;
		put(16'h8000);
		put(16'h0081);
		put(16'h8181);
		put(16'h8100);
		tick(20);
		chk("busy", 0, busy);
		chk("txlevel", 4, txl);
		@(posedge clk);
		ena <= 1'b0;
		own <= OWNER_MASTER;
		tick(20);
		chk("frozen", {1'b0, 4'h4, 5'h1f}, {busy, txl, csn});
		@(posedge clk);
		ena <= 1'b1;
		wait_idle();
		chk("heard", 64'h8000008181818100, heard);
		chk("bits", 64, bits);
		chk("selects", 1, sels);
		chk("rxlevel", 0, rxl);
		chk("others", 0, cs_other);
		$display("test bringup done");
		@(posedge clk);
		en <= 1'b0;
		cfg <= 16'h000f;
		baud <= 16'h0004;
		rxt <= 4'h2;
		@(posedge clk);
		en <= 1'b1;
		for (int i = 0; i < 8; i++)
			put(16'h1230 + i);
		wait_idle();
		for (int i = 0; i < 3; i++)
			put(16'h4560 + i);
		wait_idle();
		tick(8);
		chk("rxfull", 8, rxl);
		chk("rxovf", 1, raw[IRQ_RX_OVF]);
		chk("rxthr", 1, raw[IRQ_RX_THR]);
		for (int i = 0; i < 10; i++)
		begin
			pulse(0);
			#1;
			chk("rvalid", 1, rvalid);
			chk("rdata", 16'ha5c3, rdata);
			tick(3);
		end
		chk("rxthr", 0, raw[IRQ_RX_THR]);
		chk("rxovf", 1, raw[IRQ_RX_OVF]);
		pulse(0);
		#1;
		chk("rvalid", 0, rvalid);
		chk("rxunf", 1, raw[IRQ_RX_UNF]);
		pulse(1);
		pulse(2);
		tick(2);
		chk("rxclr", 2'b00, {raw[IRQ_RX_OVF], raw[IRQ_RX_UNF]});
		$display("test receive done");
		@(posedge clk);
		en <= 1'b0;
		txt <= 4'h4;
		mdat <= 5'h02;
		tick(3);
		chk("txthr", 1, raw[IRQ_TX_THR]);
		for (int i = 0; i < 3; i++)
			put(16'h7000 + i);
		tick(3);
		chk("txthr", 1, raw[IRQ_TX_THR]);
		put(16'h7003);
		tick(3);
		chk("txthr", 0, raw[IRQ_TX_THR]);
		for (int i = 4; i < 8; i++)
			put(16'h7000 + i);
		tick(2);
		chk("full", 1, full);
		chk("txovf", 0, raw[IRQ_TX_OVF]);
		put(16'h7777);
		tick(2);
		chk("txovf", 1, raw[IRQ_TX_OVF]);
		pulse(4);
		tick(4);
		chk("masked", 5'h02, mskd);
		chk("irq", 0, irq);
		@(posedge clk);
		en <= 1'b1;
		tick(3);
		chk("irq", 1, irq);
		pulse(3);
		tick(4);
		chk("txovf", 0, raw[IRQ_TX_OVF]);
		chk("irq", 0, irq);
		pulse(0);
		tick(2);
		chk("rxunf", 1, raw[IRQ_RX_UNF]);
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		tick(1);
		chk("rstraw", 4'h0, raw[4:1]);
		chk("rstlvl", 8'h00, {txl, rxl});
		chk("rstmask", 5'h1f, mask);
		chk("rstsel", 5'h1f, csn);
		$display("test transmit and reset done");
		close_out();
	end
endmodule : spimi_master_tb
